/* sdip_chk.sv */
// Checker
`timescale 1ns/100ps
module sdip_chk(input wire logic CLK_I,RSTN_I,SYNC_N_I,UPDATE_O,ABORT_O,OUTPUT_ENABLE_O,
   input wire logic [7:0] ANALOG_OUTPUT_CODE_O,input wire logic [1:0] POWER_MODE_O);
default clocking @(posedge CLK_I); endclocking
default disable iff(!RSTN_I);
a_code_hold: assert property(!UPDATE_O|->$stable(ANALOG_OUTPUT_CODE_O)) else $error("code");
a_mode_hold: assert property(!UPDATE_O|->$stable(POWER_MODE_O)) else $error("mode");
a_oe_decode: assert property(OUTPUT_ENABLE_O==(POWER_MODE_O==0)) else $error("oe");
a_upd_pulse: assert property(UPDATE_O|=>!UPDATE_O) else $error("upd");
a_abt_pulse: assert property(ABORT_O|=>!ABORT_O) else $error("abt");
a_abt_late: assert property(ABORT_O|->$past(SYNC_N_I)) else $error("late");
a_upd_framed: assert property(UPDATE_O|->!$past(SYNC_N_I,5)) else $error("frame");
a_one_event: assert property(!(UPDATE_O&&ABORT_O)) else $error("both");
endmodule
bind sdip_top sdip_chk chk_i(.*);

/* sdip_defs.vh */
// Constants for the serial converter input port
`ifndef SDIP_DEFS_VH
`define SDIP_DEFS_VH
`define SDIP_FRAME_BITS 16
`define SDIP_CODE_BITS 8
`define SDIP_CNT_W 5
`define SDIP_LAST_COUNT 5'h0F
`define SDIP_MODE_MSB 15
`define SDIP_MODE_LSB 14
`define SDIP_DATA_MSB 13
`define SDIP_DATA_LSB 6
`define SDIP_MODE_NORMAL 2'h0
`define SDIP_CODE_RESET 8'h00
`define SDIP_MODE_RESET 2'h0
`endif

/* sdip_host.sv */
// Host model
`timescale 1ns/100ps
module sdip_host(output logic sync_n_o,sclk_o,din_o);
initial {sync_n_o,sclk_o,din_o}=3'b110;
task send(input [15:0] w,input int n);
   sync_n_o=0;
   for(int i=15;i>15-n;i--) begin
      #80 sclk_o=1;
      din_o=w[i];
      #80 sclk_o=0;
   end
   #80 sclk_o=1;
   din_o=~din_o;
   #100 sync_n_o=1;
   #300;
endtask
endmodule

/* sdip_sync2.v */
// Two-stage synchroniser for one input level
`timescale 1ns/100ps
module sdip_sync2 #(
   parameter [0:0] RST_VAL = 1'h0
) (
   input wire CLK_I,
   input wire RSTN_I,
   input wire d_i,
   output wire q_o
);
   reg meta_reg;
   reg sync_reg;
   // Reset to the pin's idle level so no false edge follows reset
   always @(posedge CLK_I) begin
      if (!RSTN_I) begin
         meta_reg <= RST_VAL;
         sync_reg <= RST_VAL;
      end else begin
         meta_reg <= d_i;
         sync_reg <= meta_reg;
      end
   end
   assign q_o = sync_reg;
endmodule

/* sdip_top.v */
// Serial input port of an 8-bit voltage-output converter
`timescale 1ns/100ps
`include "sdip_defs.vh"
module sdip_top (
   input wire CLK_I,
   input wire RSTN_I,
   input wire SYNC_N_I,
   input wire SCLK_I,
   input wire DIN_I,
   output wire [7:0] ANALOG_OUTPUT_CODE_O,
   output wire [1:0] POWER_MODE_O,
   output wire OUTPUT_ENABLE_O,
   output wire UPDATE_O,
   output wire ABORT_O
);
   // Frame tracker states
   localparam ST_IDLE = 2'h0;
   localparam ST_SHIFT = 2'h1;
   localparam ST_DONE = 2'h2;

   // Synchronised pins and decoded events
   wire sync_n_s;
   wire sclk_s;
   wire din_s;
   wire sclk_fall;
   wire sync_fall;
   wire sync_rise;
   wire in_shift;
   wire cnt_zero;
   wire last_bit;
   wire frame_done;
   wire frame_cut;
   wire [15:0] word_shifted;
   wire [1:0] mode_field;
   wire [7:0] code_field;

   reg sclk_d_reg;
   reg sync_n_d_reg;

   // Frame state
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [15:0] shift_reg;
   reg [15:0] shift_next;
   reg [4:0] count_reg;
   reg [4:0] count_next;

   // Converter state
   reg [7:0] code_reg;
   reg [7:0] code_next;
   reg [1:0] mode_reg;
   reg [1:0] mode_next;
   reg oe_reg;
   reg oe_next;

   reg update_reg;
   reg update_next;
   reg abort_reg;
   reg abort_next;

   // Reset values match the idle pin levels so no false edge follows reset
   sdip_sync2 #(
      .RST_VAL(1'h1)
   ) u_sync_sync (
      .CLK_I(CLK_I),
      .RSTN_I(RSTN_I),
      .d_i(SYNC_N_I),
      .q_o(sync_n_s)
   );

   sdip_sync2 #(
      .RST_VAL(1'h1)
   ) u_sclk_sync (
      .CLK_I(CLK_I),
      .RSTN_I(RSTN_I),
      .d_i(SCLK_I),
      .q_o(sclk_s)
   );

   sdip_sync2 #(
      .RST_VAL(1'h0)
   ) u_din_sync (
      .CLK_I(CLK_I),
      .RSTN_I(RSTN_I),
      .d_i(DIN_I),
      .q_o(din_s)
   );

   // Sampling limits the serial clock to about a sixth of the system clock,
   // far below the 30 MHz pin rating; hosts must slow the link to match
   assign sclk_fall = sclk_d_reg & ~sclk_s;
   assign sync_fall = sync_n_d_reg & ~sync_n_s;
   assign sync_rise = ~sync_n_d_reg & sync_n_s;
   assign word_shifted = {shift_reg[14:0], din_s};
   assign mode_field = word_shifted[`SDIP_MODE_MSB:`SDIP_MODE_LSB];
   assign code_field = word_shifted[`SDIP_DATA_MSB:`SDIP_DATA_LSB];
   assign in_shift = (state_reg == ST_SHIFT);
   assign cnt_zero = (count_reg == 5'h00);
   assign last_bit = (count_reg == `SDIP_LAST_COUNT);
   assign frame_done = in_shift & ~sync_rise & sclk_fall & last_bit;
   assign frame_cut = in_shift & sync_rise & ~cnt_zero;

   // Edge detectors on the synchronised pins
   always @(posedge CLK_I) begin
      if (!RSTN_I) begin
         sclk_d_reg <= 1'h1;
         sync_n_d_reg <= 1'h1;
      end else begin
         sclk_d_reg <= sclk_s;
         sync_n_d_reg <= sync_n_s;
      end
   end

   // Frame tracker: counts falling edges while the select is low
   always @* begin
      state_next = state_reg;
      shift_next = shift_reg;
      count_next = count_reg;
      case (state_reg)
         ST_IDLE: begin
            if (sync_fall) begin
               state_next = ST_SHIFT;
               count_next = 5'h00;
               // Edge seen together with the select fall counts as first bit
               if (sclk_fall) begin
                  shift_next = word_shifted;
                  count_next = 5'h01;
               end
            end
         end
         ST_SHIFT: begin
            if (sync_rise) begin
               // Partial frame dropped, converter keeps its value
               state_next = ST_IDLE;
               count_next = 5'h00;
            end else if (sclk_fall) begin
               shift_next = word_shifted;
               if (last_bit) begin
                  state_next = ST_DONE;
                  count_next = 5'h00;
               end else begin
                  count_next = count_reg + 5'h01;
               end
            end
         end
         ST_DONE: begin
            // Clocks after the 16th are ignored until the select rises
            if (sync_rise) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always @(posedge CLK_I) begin
      if (!RSTN_I) begin
         state_reg <= ST_IDLE;
         shift_reg <= 16'h0000;
         count_reg <= 5'h00;
      end else begin
         state_reg <= state_next;
         shift_reg <= shift_next;
         count_reg <= count_next;
      end
   end

   // Converter loads only on a complete frame
   always @* begin
      code_next = code_reg;
      mode_next = mode_reg;
      oe_next = oe_reg;
      update_next = 1'h0;
      abort_next = 1'h0;
      if (frame_done) begin
         code_next = code_field;
         mode_next = mode_field;
         oe_next = (mode_field == `SDIP_MODE_NORMAL);
         update_next = 1'h1;
      end
      if (frame_cut) begin
         abort_next = 1'h1;
      end
   end

   // Power-down outputs are registered with the code so they switch together
   always @(posedge CLK_I) begin
      if (!RSTN_I) begin
         code_reg <= `SDIP_CODE_RESET;
         mode_reg <= `SDIP_MODE_RESET;
         oe_reg <= 1'h1;
         update_reg <= 1'h0;
         abort_reg <= 1'h0;
      end else begin
         code_reg <= code_next;
         mode_reg <= mode_next;
         oe_reg <= oe_next;
         update_reg <= update_next;
         abort_reg <= abort_next;
      end
   end

   // Outputs straight from flops
   assign ANALOG_OUTPUT_CODE_O = code_reg;
   assign POWER_MODE_O = mode_reg;
   assign OUTPUT_ENABLE_O = oe_reg;
   assign UPDATE_O = update_reg;
   assign ABORT_O = abort_reg;
endmodule

/* tb_top.sv */
// Bench
`timescale 1ns/100ps
module tb_top;
logic CLK_I=0,RSTN_I=0;
wire SYNC_N_I,SCLK_I,DIN_I,UPDATE_O,ABORT_O,OUTPUT_ENABLE_O;
wire [7:0] ANALOG_OUTPUT_CODE_O;
wire [1:0] POWER_MODE_O;
int n_errors=0,num_checks=0,n_upd=0,n_abt=0;
sdip_host host(.sync_n_o(SYNC_N_I),.sclk_o(SCLK_I),.din_o(DIN_I));
sdip_top dut(.CLK_I(CLK_I),.RSTN_I(RSTN_I),.SYNC_N_I(SYNC_N_I),.SCLK_I(SCLK_I),.DIN_I(DIN_I),
   .ANALOG_OUTPUT_CODE_O(ANALOG_OUTPUT_CODE_O),.POWER_MODE_O(POWER_MODE_O),
   .OUTPUT_ENABLE_O(OUTPUT_ENABLE_O),.UPDATE_O(UPDATE_O),.ABORT_O(ABORT_O));
initial forever #5 CLK_I=~CLK_I;
// Counts of the one-cycle strobes, judged after each frame except the first one of t_hold
always @(posedge CLK_I) begin
   n_upd<=n_upd+(UPDATE_O===1'b1);
   n_abt<=n_abt+(ABORT_O===1'b1);
end
task chk(input [15:0] s,e);
   num_checks++;
   n_errors+=s!==e;
   if(s!==e) $display("unexpected %0t %h %h",$time,s,e);
endtask
task end_of_test;
   if(n_errors==0&&num_checks>0) $display("bench passed");
   else $display("bench failed");
   $finish;
endtask
task t_abort;
   host.send(16'h0FFF,15);
   chk({ANALOG_OUTPUT_CODE_O,POWER_MODE_O,OUTPUT_ENABLE_O},11'h001);
   chk({n_upd[7:0],n_abt[7:0]},16'h0001);
endtask
task t_modes;
   for(int m=3;m>=0;m--) begin
      host.send({m[1:0],8'hC3>>m,6'h2A},16);
      chk({OUTPUT_ENABLE_O,POWER_MODE_O,ANALOG_OUTPUT_CODE_O},{m==0,m[1:0],8'hC3>>m});
      chk(16'(n_upd),16'(4-m));
   end
endtask
task t_hold;
   host.send(16'h1680,16);
   host.send(16'hFFFF,8);
   chk({ANALOG_OUTPUT_CODE_O,POWER_MODE_O,OUTPUT_ENABLE_O},{8'h5A,2'h0,1'h1});
   chk({n_upd[7:0],n_abt[7:0]},16'h0502);
endtask
task t_reset;
   @(posedge CLK_I);
   #1 RSTN_I=0;
   repeat(16) @(posedge CLK_I);
   #1 RSTN_I=1;
   @(posedge CLK_I);
   #1 chk({ANALOG_OUTPUT_CODE_O,POWER_MODE_O,OUTPUT_ENABLE_O},11'h001);
   host.send(16'h4FC0,16);
   chk({ANALOG_OUTPUT_CODE_O,POWER_MODE_O,OUTPUT_ENABLE_O},{8'h3F,2'h1,1'h0});
   chk({n_upd[7:0],n_abt[7:0]},16'h0602);
endtask
initial #156 RSTN_I=1;
initial begin
   #186 t_abort;
   t_modes;
   t_hold;
   t_reset;
   end_of_test;
end
initial begin
   #60000 n_errors++;
   end_of_test;
end
endmodule
